// ### tcc_cfg.svh
// Constants for the timer capture/compare channel block
// Behaviour
// RULE1 - Select bit matters only when free-running
// RULE2 - Overflow flag sets on FFFF to 0000 wrap
// RULE3 - Overflow pulse with flag, only FR/PWM; code pulses only in free-running and pulse-width
// RULE4 - Flag clears on write 0 or idle
// RULE5 - Reading flag never clears it
// RULE6 - Software write 1 cannot set flag
// RULE7 - Change select bits only while stopped
// RULE8 - Software writes zero to option bit 3
// RULE9 - Pulse-width capture only, others compare except FR
// RULE10 - Channels 16 bits, reset zero, live access
// RULE11 - Compare accepts writes while counting
// RULE12 - Buffer match raises channel match pulse
// RULE13 - Match toggles pin when output enabled
// RULE14 - Channel 0 sets period in compare modes
// RULE15 - Free-running capture latches count on edge
// RULE16 - Pulse-width capture latches and clears counter
// RULE17 - Capture during read returns consistent value
// RULE18 - Anytime write or batch write by mode
// RULE19 - No access on subclock or internal oscillator
// RULE20 - Two-bit edge select: none, rise, fall, both
// RULE21 - Three-bit mode field encodes eight modes
// RULE22 - Interrupt requests are one-cycle pulses
// RULE23 - Capture pins synchronised before edge detection
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH
`define TCC_NCH 4
`define TCC_AW 4
`define TCC_A_CCR0 4'h0
`define TCC_A_CCR1 4'h1
`define TCC_A_CCR2 4'h2
`define TCC_A_CCR3 4'h3
`define TCC_A_OPT 4'h4
`define TCC_A_CTRL 4'h5
`define TCC_A_EDGE 4'h6
`define TCC_A_OUT 4'h7
`define TCC_A_CNT 4'h8
`define TCC_OVF_BIT 0
`define TCC_CCS_LSB 4
`define TCC_OPTLO_LSB 1
`define TCC_OL_LSB 4
`define TCC_CE_BIT 0
`define TCC_MODE_LSB 1
`define TCC_CNT_MAX 16'hffff
`define TCC_ZERO16 16'h0000
`endif

// ### tcc_pkg.sv
// Types for the timer capture/compare channel block
package tcc_pkg;
   // RULE21 eight mode codes
   typedef enum logic [2:0] {
      TCC_INTERVAL = 3'h0,
      TCC_EVENT = 3'h1,
      TCC_EXTTRIG = 3'h2,
      TCC_ONESHOT = 3'h3,
      TCC_PWM = 3'h4,
      TCC_FREERUN = 3'h5,
      TCC_PULSEW = 3'h6,
      TCC_TRIPWM = 3'h7
   } tcc_mode_t;
   typedef enum logic [1:0] {
      TCC_EDGE_NONE = 2'h0,
      TCC_EDGE_RISE = 2'h1,
      TCC_EDGE_FALL = 2'h2,
      TCC_EDGE_BOTH = 2'h3
   } tcc_edge_t;
endpackage

// ### tcc_capsync.sv
// Capture pin synchroniser and valid-edge detector
module tcc_capsync (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Pin and edge choice
   input wire logic pin,
   input wire logic [1:0] edge_sel,
   // Detected valid edge
   output logic edge_det
);
   logic s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;

   always_comb begin
      s1_d = pin;
      s2_d = s1_q;
      s3_d = s2_q;
   end

   // RULE23 two flops then history
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
      end
   end

   // RULE20 edge selection
   always_comb begin
      case (tcc_pkg::tcc_edge_t'(edge_sel))
         tcc_pkg::TCC_EDGE_RISE: edge_det = s2_q & ~s3_q;
         tcc_pkg::TCC_EDGE_FALL: edge_det = ~s2_q & s3_q;
         tcc_pkg::TCC_EDGE_BOTH: edge_det = s2_q ^ s3_q;
         default: edge_det = 1'b0;
      endcase
   end
endmodule

// ### tcc_channels.sv
// Timer capture/compare channels with counter and overflow detection
//
// Chosen here: strobed register access and the register addresses.
`include "tcc_cfg.svh"
module tcc_channels (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Register port
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   // Count clock tick
   input wire logic count_tick,
   // Capture pins
   input wire logic [3:0] capture_pin,
   // Output pins
   output logic [3:0] out_pin,
   // Interrupt pulses
   output logic [3:0] match_irq,
   output logic overflow_irq
);
   // ****************************************************************
   // State
   // ****************************************************************
   logic [15:0] ccr_q [4];
   logic [15:0] ccr_d [4];
   logic [15:0] buf_q [4];
   logic [15:0] buf_d [4];
   logic [15:0] cnt_q, cnt_d;
   logic [3:0] ccs_q, ccs_d;
   logic [2:0] optlo_q, optlo_d;
   logic ovf_q, ovf_d;
   logic ce_q, ce_d;
   logic [2:0] mode_q, mode_d;
   logic [7:0] edge_q, edge_d;
   logic [3:0] oe_q, oe_d;
   logic [3:0] ol_q, ol_d;
   logic [3:0] tog_q, tog_d;
   logic [3:0] mirq_q, mirq_d;
   logic oirq_q, oirq_d;
   logic [15:0] rdata_q, rdata_d;
   logic ce_prev_q;
   logic [3:0] cap_edge;
   logic [3:0] is_cap;
   logic [3:0] match;
   logic wrap, batch, period_mode, pw_clr, start;

   // ****************************************************************
   // Capture edges
   // ****************************************************************
   for (genvar i = 0; i < `TCC_NCH; i++) begin : g_sync
      tcc_capsync u_sync (
         .clk(clk),
         .rstn(rstn),
         .pin(capture_pin[i]),
         .edge_sel(edge_q[2*i+:2]),
         .edge_det(cap_edge[i])
      );
   end

   function automatic logic mode_is(input logic [2:0] m, input tcc_pkg::tcc_mode_t t);
      mode_is = (m == t);
   endfunction

   // ****************************************************************
   // Mode decode
   // ****************************************************************
   always_comb begin
      for (int i = 0; i < `TCC_NCH; i++) begin
         // RULE1 RULE9 channel role
         if (mode_is(mode_q, tcc_pkg::TCC_PULSEW)) begin
            is_cap[i] = 1'b1;
         end else if (mode_is(mode_q, tcc_pkg::TCC_FREERUN)) begin
            is_cap[i] = ccs_q[i];
         end else begin
            is_cap[i] = 1'b0;
         end
      end
      // RULE18 batch write modes
      batch = mode_is(mode_q, tcc_pkg::TCC_EXTTRIG) | mode_is(mode_q, tcc_pkg::TCC_PWM)
         | mode_is(mode_q, tcc_pkg::TCC_TRIPWM);
      period_mode = ~mode_is(mode_q, tcc_pkg::TCC_FREERUN)
         & ~mode_is(mode_q, tcc_pkg::TCC_PULSEW);
      start = ce_q & ~ce_prev_q;
      for (int i = 0; i < `TCC_NCH; i++) begin
         // RULE12 counter equals buffer
         match[i] = ce_q & count_tick & ~is_cap[i] & (cnt_q == buf_q[i]);
      end
      pw_clr = mode_is(mode_q, tcc_pkg::TCC_PULSEW) & ce_q & (|cap_edge);
      // RULE2 wrap in free-running or pulse-width
      wrap = ce_q & count_tick & ~period_mode & ~pw_clr & (cnt_q == `TCC_CNT_MAX);
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      ccs_d = ccs_q;
      optlo_d = optlo_q;
      ce_d = ce_q;
      mode_d = mode_q;
      edge_d = edge_q;
      oe_d = oe_q;
      ol_d = ol_q;
      ccr_d = ccr_q;
      buf_d = buf_q;
      tog_d = tog_q;
      cnt_d = cnt_q;
      ovf_d = ovf_q;
      // RULE10 RULE11 whole-word writes at any time
      if (wr && addr == `TCC_A_CCR0) begin
         ccr_d[0] = wdata;
      end else if (wr && addr == `TCC_A_CCR1) begin
         ccr_d[1] = wdata;
      end else if (wr && addr == `TCC_A_CCR2) begin
         ccr_d[2] = wdata;
      end else if (wr && addr == `TCC_A_CCR3) begin
         ccr_d[3] = wdata;
      end else if (wr && addr == `TCC_A_OPT) begin
         // RULE7 software changes these only when stopped
         ccs_d = wdata[`TCC_CCS_LSB+:4];
         // RULE8 bit 3 kept as software wrote it
         optlo_d = wdata[`TCC_OPTLO_LSB+:3];
      end else if (wr && addr == `TCC_A_CTRL) begin
         ce_d = wdata[`TCC_CE_BIT];
         mode_d = wdata[`TCC_MODE_LSB+:3];
      end else if (wr && addr == `TCC_A_EDGE) begin
         edge_d = wdata[7:0];
      end else if (wr && addr == `TCC_A_OUT) begin
         oe_d = wdata[3:0];
         ol_d = wdata[`TCC_OL_LSB+:4];
      end
      for (int i = 0; i < `TCC_NCH; i++) begin
         // RULE18 anytime write or load at period end/start
         if (!batch || start || !ce_q || (match[0] && period_mode)) begin
            buf_d[i] = ccr_d[i];
         end
         // RULE15 RULE16 latch count on valid edge
         if (ce_q && is_cap[i] && cap_edge[i]) begin
            ccr_d[i] = cnt_q;
         end
         // RULE13 toggle on match
         if (match[i] && oe_q[i]) begin
            tog_d[i] = ~tog_q[i];
         end
      end
      if (!ce_q) begin
         cnt_d = `TCC_ZERO16;
         tog_d = 4'h0;
      end else if (pw_clr) begin
         // RULE16 clear on capture
         cnt_d = `TCC_ZERO16;
      end else if (count_tick) begin
         // RULE14 channel 0 period
         if (period_mode && match[0]) begin
            cnt_d = `TCC_ZERO16;
         end else begin
            cnt_d = cnt_q + 16'h0001;
         end
      end
      // RULE4 RULE5 RULE6 write 0 clears, 1 ignored, reads no effect
      if (wr && addr == `TCC_A_OPT && !wdata[`TCC_OVF_BIT]) begin
         ovf_d = 1'b0;
      end
      if (!ce_d) begin
         ovf_d = 1'b0;
      end
      // RULE2 set wins over software clear
      if (wrap) begin
         ovf_d = 1'b1;
      end
      // RULE22 RULE3 one-cycle pulses
      mirq_d = match;
      oirq_d = wrap;
      // RULE17 read samples a settled register
      if (!rd) begin
         rdata_d = `TCC_ZERO16;
      end else if (addr == `TCC_A_CCR0) begin
         rdata_d = ccr_q[0];
      end else if (addr == `TCC_A_CCR1) begin
         rdata_d = ccr_q[1];
      end else if (addr == `TCC_A_CCR2) begin
         rdata_d = ccr_q[2];
      end else if (addr == `TCC_A_CCR3) begin
         rdata_d = ccr_q[3];
      end else if (addr == `TCC_A_OPT) begin
         rdata_d = {8'h00, ccs_q, optlo_q, ovf_q};
      end else if (addr == `TCC_A_CTRL) begin
         rdata_d = {12'h000, mode_q, ce_q};
      end else if (addr == `TCC_A_EDGE) begin
         rdata_d = {8'h00, edge_q};
      end else if (addr == `TCC_A_OUT) begin
         rdata_d = {8'h00, ol_q, oe_q};
      end else if (addr == `TCC_A_CNT) begin
         rdata_d = cnt_q;
      end else begin
         rdata_d = `TCC_ZERO16;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < `TCC_NCH; i++) begin
            ccr_q[i] <= `TCC_ZERO16;
            buf_q[i] <= `TCC_ZERO16;
         end
         cnt_q <= `TCC_ZERO16;
         ccs_q <= 4'h0;
         optlo_q <= 3'h0;
         ovf_q <= 1'b0;
         ce_q <= 1'b0;
         ce_prev_q <= 1'b0;
         mode_q <= 3'h0;
         edge_q <= 8'h00;
         oe_q <= 4'h0;
         ol_q <= 4'h0;
         tog_q <= 4'h0;
         mirq_q <= 4'h0;
         oirq_q <= 1'b0;
         rdata_q <= `TCC_ZERO16;
      end else begin
         ccr_q <= ccr_d;
         buf_q <= buf_d;
         cnt_q <= cnt_d;
         ccs_q <= ccs_d;
         optlo_q <= optlo_d;
         ovf_q <= ovf_d;
         ce_q <= ce_d;
         ce_prev_q <= ce_q;
         mode_q <= mode_d;
         edge_q <= edge_d;
         oe_q <= oe_d;
         ol_q <= ol_d;
         tog_q <= tog_d;
         mirq_q <= mirq_d;
         oirq_q <= oirq_d;
         rdata_q <= rdata_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign rdata = rdata_q;
   assign match_irq = mirq_q;
   assign overflow_irq = oirq_q;
   // Disabled output shows level bit; enabled starts at its inverse
   assign out_pin = (oe_q & (~ol_q ^ tog_q)) | (~oe_q & ol_q);

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_ovf_set; // RULE2
      @(posedge clk) disable iff (!rstn) wrap |=> ovf_q;
   endproperty
   a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set on wrap");

   property p_ovf_irq; // RULE3
      @(posedge clk) disable iff (!rstn) overflow_irq |-> ovf_q;
   endproperty
   a_ovf_irq: assert property (p_ovf_irq) else $error("overflow pulse without flag");

   property p_ovf_mode; // RULE3
      @(posedge clk) disable iff (!rstn)
         overflow_irq |-> $past(mode_q) == tcc_pkg::TCC_FREERUN
         || $past(mode_q) == tcc_pkg::TCC_PULSEW;
   endproperty
   a_ovf_mode: assert property (p_ovf_mode) else $error("overflow pulse in wrong mode");

   property p_ovf_ce; // RULE4
      @(posedge clk) disable iff (!rstn) !ce_q |-> !ovf_q;
   endproperty
   a_ovf_ce: assert property (p_ovf_ce) else $error("overflow flag held while stopped");

   property p_ovf_sw; // RULE6
      @(posedge clk) disable iff (!rstn) !ovf_q && !wrap |=> !ovf_q;
   endproperty
   a_ovf_sw: assert property (p_ovf_sw) else $error("overflow flag set without wrap");

   property p_irq_pulse; // RULE22
      @(posedge clk) disable iff (!rstn) overflow_irq |=> !overflow_irq;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("overflow pulse too long");

   property p_match_irq; // RULE12
      @(posedge clk) disable iff (!rstn) match[1] |=> match_irq[1];
   endproperty
   a_match_irq: assert property (p_match_irq) else $error("match pulse missing");

   property p_period; // RULE14
      @(posedge clk) disable iff (!rstn)
         period_mode && match[0] && !pw_clr |=> cnt_q == `TCC_ZERO16;
   endproperty
   a_period: assert property (p_period) else $error("counter not cleared at period");

   property p_toggle; // RULE13
      @(posedge clk) disable iff (!rstn) match[2] && oe_q[2] && ce_d |=> tog_q[2] != $past(tog_q[2]);
   endproperty
   a_toggle: assert property (p_toggle) else $error("output not toggled on match");
endmodule

// ### tcc_pin_model.sv
// Far-side model: capture pin source and output pin monitor
module tcc_pin_model (
   // Clock
   input wire logic clk,
   // Pins
   output logic [3:0] cap_pin,
   input wire logic [3:0] out_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] out_last;
   logic [7:0] tog1;
   initial begin
      cap_pin = 4'h0;
      out_last = 4'h0;
      tog1 = 8'h00;
   end
   // Count level changes on channel 1 output
   always @(posedge clk) begin
      if (out_pin[1] !== out_last[1]) begin
         tog1 <= tog1 + 8'h01;
      end
      out_last <= out_pin;
   end
   // One clean high pulse, long enough for the synchroniser
   task automatic pulse(input int ch);
      @(posedge clk);
      cap_pin[ch] <= 1'b1;
      repeat (4) @(posedge clk);
      cap_pin[ch] <= 1'b0;
   endtask
endmodule

// ### tb_top.sv
// Testbench for the capture/compare channel block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rstn, wr, rd, count_tick;
   logic [3:0] addr, out_pin, match_irq, capture_pin;
   logic [15:0] wdata, rdata, d, e;
   logic overflow_irq;
   int errors, checks_done, n;
   logic [4:0] irq_all;
   assign irq_all = {overflow_irq, match_irq};
   tcc_channels dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .count_tick(count_tick), .capture_pin(capture_pin),
      .out_pin(out_pin), .match_irq(match_irq), .overflow_irq(overflow_irq));
   tcc_pin_model u_pins (.clk(clk), .cap_pin(capture_pin), .out_pin(out_pin));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ****************
   // Bus tasks
   // one main clock, never a slow one
   // ****************
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Wait for one interrupt line, bounded
   task automatic wait_irq(input int which, input int lim);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (irq_all[which] !== 1'b1 && n < lim);
      if (n >= lim) check(16'h0001, 16'h0000);
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      #(90000 * 5);
      errors++;
      final_report;
   end
   // ****************
   // Tests
   // ****************
   initial begin
      errors = 0;
      checks_done = 0;
      rstn = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 16'h0000;
      count_tick = 1'b1;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      // Reset values and unmapped read
      for (int i = 0; i < 9; i++) if (i < 5 || i == 8) begin
         rd_reg(4'(i), d);
         check(d, 16'h0000);
      end
      rd_reg(4'hf, d);
      check(d, 16'h0000);
      wr_reg(4'h3, 16'ha5c3);
      rd_reg(4'h3, d);
      check(d, 16'ha5c3);
      // Interval mode, ch1 select set but ignored; selects changed while stopped
      // stopped, bit 3 zero
      wr_reg(4'h4, 16'h0020);
      wr_reg(4'h0, 16'h0009);
      wr_reg(4'h1, 16'h0003);
      wr_reg(4'h7, 16'h0006);
      wr_reg(4'h5, 16'h0001);
      wait_irq(0, 100);
      wait_irq(0, 100);
      check(16'(n), 16'h000a);
      d = 16'(u_pins.tog1);
      e = 16'h0000;
      repeat (30) @(posedge clk) if (match_irq[1] === 1'b1) e++;
      check(e, 16'h0003);
      check(16'(8'(u_pins.tog1 - d[7:0])), 16'h0003);
      wr_reg(4'h1, 16'h0005);
      rd_reg(4'h1, d);
      check(d, 16'h0005);
      rd_reg(4'h4, d);
      check(d & 16'h0001, 16'h0000);
      // Free-running capture on ch2 rising edge
      wr_reg(4'h5, 16'h0000);
      repeat (2) @(posedge clk);
      check(16'(out_pin), 16'h0006);
      wr_reg(4'h4, 16'h0040);
      wr_reg(4'h6, 16'h0010);
      wr_reg(4'h5, 16'h000b);
      repeat (20) @(posedge clk);
      u_pins.pulse(2);
      repeat (4) @(posedge clk);
      rd_reg(4'h2, d);
      rd_reg(4'h8, e);
      check(16'(d != 0 && d < e), 16'h0001);
      // Overflow flag behaviour
      wait_irq(4, 70000);
      rd_reg(4'h4, d);
      check(d & 16'h0001, 16'h0001);
      rd_reg(4'h4, d);
      check(d & 16'h0001, 16'h0001);
      wr_reg(4'h4, 16'h0041);
      rd_reg(4'h4, d);
      check(d & 16'h0001, 16'h0001);
      wr_reg(4'h4, 16'h0040);
      rd_reg(4'h4, d);
      check(d & 16'h0001, 16'h0000);
      wr_reg(4'h4, 16'h0041);
      rd_reg(4'h4, d);
      check(d & 16'h0001, 16'h0000);
      // Pulse-width mode, ch0 captures and clears counter
      wr_reg(4'h5, 16'h0000);
      wr_reg(4'h6, 16'h0001);
      wr_reg(4'h5, 16'h000d);
      repeat (40) @(posedge clk);
      u_pins.pulse(0);
      repeat (2) @(posedge clk);
      rd_reg(4'h0, d);
      rd_reg(4'h8, e);
      check(16'(d > 16'h0020 && e < d), 16'h0001);
      // PWM mode, compare writes wait for the period end
      wr_reg(4'h5, 16'h0000);
      wr_reg(4'h0, 16'h0063);
      wr_reg(4'h1, 16'h0005);
      wr_reg(4'h5, 16'h0009);
      wait_irq(0, 200);
      wr_reg(4'h1, 16'h0030);
      wait_irq(1, 200);
      check(16'(n), 16'h0004);
      wait_irq(0, 200);
      wait_irq(1, 200);
      check(16'(n), 16'h0031);
      final_report;
   end
endmodule
